// File: inc/wdr_pkg.sv
// Package of constants and types for the watchdog register interface.
package wdr_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets.
   // ----------------------------------------------------------------
   localparam logic [11:0] OFF_START = 12'h000;
   localparam logic [11:0] OFF_EXPIRY = 12'h100;
   localparam logic [11:0] OFF_INTEN_SET = 12'h304;
   localparam logic [11:0] OFF_INTEN_CLR = 12'h308;
   localparam logic [11:0] OFF_RUN_STATE = 12'h400;
   localparam logic [11:0] OFF_REQ_STATE = 12'h404;
   localparam logic [11:0] OFF_RELOAD_CNT = 12'h504;
   localparam logic [11:0] OFF_SLOT_EN = 12'h508;
   localparam logic [11:0] OFF_PAUSE_CFG = 12'h50C;
   localparam logic [11:0] OFF_SLOT_BASE = 12'h600;
   localparam logic [11:0] OFF_SLOT_LAST = 12'h61C;

   // ----------------------------------------------------------------
   // Reset values, field positions and magic value.
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_RELOAD_CNT = 32'hFFFFFFFF;
   localparam logic [7:0] RST_SLOT_EN = 8'h01;
   localparam logic [1:0] RST_PAUSE_CFG = 2'h1;
   localparam logic [31:0] MIN_RELOAD_CNT = 32'h0000000F;
   localparam logic [31:0] RELOAD_MAGIC = 32'h6E524635;
   localparam int CFG_SLEEP_BIT = 0;
   localparam int CFG_HALT_BIT = 3;
   localparam int NUM_SLOTS = 8;

   // ----------------------------------------------------------------
   // Timing: system clock and low-frequency tick.
   // ----------------------------------------------------------------
   localparam int REF_CLK_HZ = 20000000;
   localparam int LF_CLK_HZ = 32768;
   // Ticks of the 20 MHz clock per low-frequency cycle, rounded down.
   localparam int LF_DIV_CYCLES = REF_CLK_HZ / LF_CLK_HZ;
   localparam logic [9:0] LF_DIV_LAST = 10'(LF_DIV_CYCLES - 1);
   // Reset postponement in low-frequency cycles with interrupt enabled.
   localparam logic [1:0] RESET_DELAY_LF = 2'h2;

   // Watchdog sequence states.
   typedef enum logic [3:0] {
      WDR_IDLE = 4'b0001,
      WDR_RUN = 4'b0010,
      WDR_HOLD = 4'b0100,
      WDR_FIRE = 4'b1000
   } wdr_state_e;

   // APB request carried as one bundle.
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } wdr_apb_req_s;

endpackage

// File: logic/wdr_watchdog.sv
// Watchdog down-counter with its APB register interface.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module wdr_watchdog
   import wdr_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic nrst,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Processor state pins, asynchronous.
   input wire logic cpuSleep,
   input wire logic cpuHalt,
   // Outputs to the system.
   output logic irq,
   output logic wdtResetReq
);

   // ----------------------------------------------------------------
   // Declarations.
   // ----------------------------------------------------------------
   wdr_apb_req_s req;
   wdr_state_e state_q, state_d;
   logic [1:0] sleepSync_q, haltSync_q;
   logic [9:0] div_q;
   logic lfTick;
   logic [31:0] count_q;
   logic [31:0] reload_q;
   logic [7:0] slotEn_q;
   logic [1:0] cfg_q;
   logic [7:0] pending_q;
   logic expiry_q, intEn_q;
   logic [1:0] delay_q;
   logic [31:0] prdata_q;
   logic wrAcc, rdAcc, started, paused, expire, reloadNow;
   logic hitStart, hitExp, hitSet, hitClr, hitRun, hitReq;
   logic hitCnt, hitEn, hitCfg, hitSlot, mapped, magic;
   logic [2:0] slotIdx;
   logic [7:0] slotFed;
   logic [31:0] rdMux;
   logic ack_q, rdLaunch;

   // ----------------------------------------------------------------
   // Bus decode. Every access has one wait state, so that read data
   // comes from a register rather than straight from the multiplexer.
   // ----------------------------------------------------------------
   assign req = '{sel: psel, enable: penable, write: pwrite,
                  addr: paddr, wdata: pwdata};
   assign pready = ack_q;
   // Writes and errors take effect only at the completing edge.
   assign wrAcc = req.sel && req.enable && req.write && ack_q;
   assign rdAcc = req.sel && req.enable && !req.write && ack_q;
   assign rdLaunch = req.sel && req.enable && !req.write && !ack_q;
   assign hitStart = req.addr == OFF_START;
   assign hitExp = req.addr == OFF_EXPIRY;
   assign hitSet = req.addr == OFF_INTEN_SET;
   assign hitClr = req.addr == OFF_INTEN_CLR;
   assign hitRun = req.addr == OFF_RUN_STATE;
   assign hitReq = req.addr == OFF_REQ_STATE;
   assign hitCnt = req.addr == OFF_RELOAD_CNT;
   assign hitEn = req.addr == OFF_SLOT_EN;
   assign hitCfg = req.addr == OFF_PAUSE_CFG;
   assign hitSlot = req.addr >= OFF_SLOT_BASE &&
                    req.addr <= OFF_SLOT_LAST && req.addr[1:0] == 2'h0;
   assign mapped = hitStart | hitExp | hitSet | hitClr | hitRun |
                   hitReq | hitCnt | hitEn | hitCfg | hitSlot;
   // Unmapped addresses answer with an error; misses never write.
   assign pslverr = req.sel && req.enable && ack_q && !mapped;
   assign slotIdx = req.addr[4:2];
   assign magic = req.wdata == RELOAD_MAGIC;
   assign started = state_q != WDR_IDLE;

   // Read multiplexer; slots are write-only and read as zero.
   assign rdMux = hitExp ? {31'h0, expiry_q} :
                  (hitSet | hitClr) ? {31'h0, intEn_q} :
                  hitRun ? {31'h0, started} :
                  hitReq ? {24'h0, pending_q} :
                  hitCnt ? reload_q :
                  hitEn ? {24'h0, slotEn_q} :
                  hitCfg ? {28'h0, cfg_q[1], 2'h0, cfg_q[0]} :
                  32'h0;

   // Ready rises in the second access cycle and drops after completion.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req.sel && req.enable && !ack_q;
      end
   end

   // Read data captured in the wait cycle and held until the next read.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prdata_q <= 32'h0;
      end else if (rdLaunch) begin
         prdata_q <= rdMux;
      end
   end
   assign prdata = prdata_q;

   // ----------------------------------------------------------------
   // Pin synchronisers and low-frequency tick divider.
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sleepSync_q <= 2'h0;
         haltSync_q <= 2'h0;
      end else begin
         sleepSync_q <= {sleepSync_q[0], cpuSleep};
         haltSync_q <= {haltSync_q[0], cpuHalt};
      end
   end

   // The tick approximates 32.768 kHz; the integer divide costs accuracy.
   assign lfTick = div_q == LF_DIV_LAST;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         div_q <= 10'h0;
      end else begin
         div_q <= lfTick ? 10'h0 : div_q + 10'h1;
      end
   end

   // Counting stops in sleep or halt unless configured to run.
   assign paused = (sleepSync_q[1] && !cfg_q[0]) ||
                   (haltSync_q[1] && !cfg_q[1]);

   // ----------------------------------------------------------------
   // Configuration registers, locked once started.
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         reload_q <= RST_RELOAD_CNT;
         slotEn_q <= RST_SLOT_EN;
         cfg_q <= RST_PAUSE_CFG;
      end else if (wrAcc && !started) begin
         if (hitCnt) begin
            reload_q <= req.wdata;
         end
         if (hitEn) begin
            slotEn_q <= req.wdata[7:0];
         end
         if (hitCfg) begin
            cfg_q <= {req.wdata[CFG_HALT_BIT], req.wdata[CFG_SLEEP_BIT]};
         end
      end
   end

   // ----------------------------------------------------------------
   // Reload slots: one pending bit per slot, rearmed on reload.
   // ----------------------------------------------------------------
   assign slotFed = (wrAcc && hitSlot && magic) ?
                    (8'h01 << slotIdx) : 8'h00;
   // Reload when no enabled slot remains pending after this write.
   assign reloadNow = state_q == WDR_RUN &&
                      ((pending_q & ~slotFed) == 8'h00);
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pending_q <= 8'h00;
      end else if (!started || reloadNow) begin
         pending_q <= slotEn_q;
      end else begin
         pending_q <= pending_q & ~slotFed;
      end
   end

   // ----------------------------------------------------------------
   // Down-counter: period is (count + 1) low-frequency cycles.
   // ----------------------------------------------------------------
   assign expire = state_q == WDR_RUN && lfTick && !paused &&
                   count_q == 32'h0 && !reloadNow;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         count_q <= RST_RELOAD_CNT;
      end else if (!started || reloadNow) begin
         count_q <= reload_q;
      end else if (state_q == WDR_RUN && lfTick && !paused &&
                   count_q != 32'h0) begin
         count_q <= count_q - 32'h1;
      end
   end

   // ----------------------------------------------------------------
   // Sequence: idle, run, optional two-cycle hold, then reset.
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         WDR_IDLE: begin
            if (wrAcc && hitStart && req.wdata[0]) begin
               state_d = WDR_RUN;
            end
         end
         WDR_RUN: begin
            if (expire) begin
               state_d = intEn_q ? WDR_HOLD : WDR_FIRE;
            end
         end
         WDR_HOLD: begin
            if (lfTick && delay_q == RESET_DELAY_LF - 2'h1) begin
               state_d = WDR_FIRE;
            end
         end
         WDR_FIRE: state_d = WDR_FIRE;
         default: state_d = WDR_IDLE;
      endcase
   end

   // Hold counter for the postponed reset; unpausable once expired.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= WDR_IDLE;
         delay_q <= 2'h0;
      end else begin
         state_q <= state_d;
         if (state_q != WDR_HOLD) begin
            delay_q <= 2'h0;
         end else if (lfTick) begin
            delay_q <= delay_q + 2'h1;
         end
      end
   end
   // Reset stays requested until the system reset clears the block.
   assign wdtResetReq = state_q == WDR_FIRE;

   // ----------------------------------------------------------------
   // Event flag, interrupt enable and interrupt output.
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         expiry_q <= 1'b0;
         intEn_q <= 1'b0;
      end else begin
         // A new expiry wins over a clearing write in the same cycle.
         if (expire) begin
            expiry_q <= 1'b1;
         end else if (wrAcc && hitExp) begin
            expiry_q <= req.wdata[0];
         end
         if (wrAcc && hitSet && req.wdata[0]) begin
            intEn_q <= 1'b1;
         end else if (wrAcc && hitClr && req.wdata[0]) begin
            intEn_q <= 1'b0;
         end
      end
   end
   assign irq = expiry_q && intEn_q;

   // ----------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   a_expiry_sets_flag: assert property (
      expire |=> expiry_q) else $error("expiry did not set flag");
   a_set_enables_irq: assert property (
      wrAcc && hitSet && req.wdata[0] |=> intEn_q)
      else $error("enable-set write ignored");
   a_set_zero_noop: assert property (
      wrAcc && hitSet && !req.wdata[0] && !intEn_q |=> !intEn_q)
      else $error("zero write changed enable");
   a_reload_locked: assert property (
      started |=> $stable(reload_q) && $stable(slotEn_q) && $stable(cfg_q))
      else $error("config changed while running");
   a_reload_count_load: assert property (
      wrAcc && hitCnt && !started |=> reload_q == $past(req.wdata))
      else $error("reload count not stored");
   a_slot_en_load: assert property (
      wrAcc && hitEn && !started |=> slotEn_q == $past(req.wdata[7:0]))
      else $error("slot enable not stored");
   a_sleep_pause: assert property (
      state_q == WDR_RUN && sleepSync_q[1] && !cfg_q[0] && !reloadNow
      |=> $stable(count_q)) else $error("counter ran in sleep");
   a_halt_pause: assert property (
      state_q == WDR_RUN && haltSync_q[1] && !cfg_q[1] && !reloadNow
      |=> $stable(count_q)) else $error("counter ran in halt");
   a_non_magic_ignored: assert property (
      wrAcc && hitSlot && !magic && state_q == WDR_RUN &&
      pending_q != 8'h00 |=> pending_q == $past(pending_q))
      else $error("non-magic write fed slot");
   a_reload_all_fed: assert property (
      reloadNow |=> count_q == $past(reload_q))
      else $error("reload did not load count");
   a_req_rearm: assert property (
      reloadNow |=> pending_q == $past(slotEn_q))
      else $error("pending not rearmed");
   a_direct_reset: assert property (
      expire && !intEn_q |=> wdtResetReq)
      else $error("reset not immediate");
   a_postponed_reset: assert property (
      expire && intEn_q |=> !wdtResetReq [*8])
      else $error("postponed reset came early");
   a_run_state_read: assert property (
      rdAcc && hitRun |-> prdata[0] == $past(started))
      else $error("run state read wrong");
   a_slot_reads_zero: assert property (
      rdAcc && hitSlot |-> prdata == 32'h00000000)
      else $error("slot read not zero");
   a_expiry_clear: assert property (
      wrAcc && hitExp && !req.wdata[0] && !expire |=> !expiry_q)
      else $error("flag clear write ignored");
   a_reset_sticky: assert property (
      wdtResetReq |=> wdtResetReq)
      else $error("reset request dropped");

   c_start: cover property (wrAcc && hitStart && !started);
   c_reload: cover property (reloadNow && slotFed != 8'h00);
   c_postponed: cover property (state_q == WDR_HOLD ##1 wdtResetReq);
   c_unmapped: cover property (pslverr);
   c_paused: cover property (state_q == WDR_RUN && paused);

endmodule

`default_nettype wire

// File: dv/wdr_watchdog_tb_top.sv
// Self-checking testbench for the watchdog register interface.
`timescale 1ns/1ps
`default_nettype none
module wdr_watchdog_tb_top;
   import wdr_pkg::*;
   localparam int TICK = LF_DIV_CYCLES;
   localparam int LIMIT = 90000;
   logic ref_clk, nrst, psel, penable, pwrite, cpuSleep, cpuHalt;
   logic pready, pslverr, irq, wdtResetReq, errSeen;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, v;
   logic [7:0] slotEn;
   int err_count = 0;
   int n_checks = 0;
   int cycles = 0;
   int n;

   wdr_watchdog DUT (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpuSleep(cpuSleep), .cpuHalt(cpuHalt), .irq(irq),
      .wdtResetReq(wdtResetReq));

   // 20 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Hang guard: a stuck wait must not hide behind a silent run.
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         err_count++;
         summarize();
      end
   end

   // ----------------------------------------------------------------
   // Bus cycles and comparisons.
   // ----------------------------------------------------------------
   // Counts and verdict, then ends the run.
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Compares a register word or a flag widened to a word.
   task automatic check32(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Compares a measured cycle count against a window.
   task automatic check_range(input int got, input int lo, input int hi);
      n_checks++;
      if (got < lo || got > hi) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h to %h", $time,
            got, lo, hi);
      end
   endtask

   // One APB transfer; one idle edge follows so psel never toggles twice.
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) begin
         @(posedge ref_clk);
      end
      rd = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic reg_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      check32(rd, exp);
   endtask

   // Bounded wait for the interrupt or the reset request; n holds cycles.
   task automatic wait_hi(input logic useReset, input int max);
      n = 0;
      while (((useReset ? wdtResetReq : irq) !== 1'b1) && n < max) begin
         n++;
         @(posedge ref_clk);
      end
   endtask

   // Probes every slot with a wrong word, then the reload word.
   task automatic feed_all();
      logic [7:0] pend;
      pend = slotEn;
      for (int i = 0; i < NUM_SLOTS; i++) begin
         reg_wr(12'(OFF_SLOT_BASE + 4 * i), RELOAD_MAGIC ^ ($urandom | 1));
         reg_chk(OFF_REQ_STATE, 32'(pend));
         reg_wr(12'(OFF_SLOT_BASE + 4 * i), RELOAD_MAGIC);
         pend[i] = 1'b0;
         pend = (pend == 8'h00) ? slotEn : pend;
         reg_chk(OFF_REQ_STATE, 32'(pend));
      end
   endtask

   task automatic do_reset();
      nrst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
   endtask

   // ----------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------
   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      cpuSleep = 1'b0;
      cpuHalt = 1'b0;
      void'($urandom(32'h31B8BE3F));
      do_reset();
      reg_chk(OFF_RELOAD_CNT, RST_RELOAD_CNT);
      reg_chk(OFF_SLOT_EN, 32'(RST_SLOT_EN));
      reg_chk(OFF_PAUSE_CFG, 32'(RST_PAUSE_CFG));
      reg_chk(OFF_EXPIRY, 32'h00000000);
      reg_chk(OFF_RUN_STATE, 32'h00000000);
      reg_chk(OFF_REQ_STATE, 32'(RST_SLOT_EN));
      reg_chk(OFF_SLOT_BASE, 32'h00000000);
      apb(1'b0, 12'h7F0, 32'h00000000);
      check32(32'(errSeen), 32'h00000001);
      check32(32'(pready), 32'h00000000);
      reg_wr(OFF_INTEN_SET, 32'h00000000);
      reg_chk(OFF_INTEN_SET, 32'h00000000);
      reg_wr(OFF_INTEN_SET, 32'h00000001);
      reg_chk(OFF_INTEN_CLR, 32'h00000001);
      reg_wr(OFF_INTEN_CLR, 32'h00000001);
      reg_chk(OFF_INTEN_SET, 32'h00000000);
      repeat (4) begin
         v = $urandom | MIN_RELOAD_CNT;
         reg_wr(OFF_RELOAD_CNT, v);
         reg_chk(OFF_RELOAD_CNT, v);
         v = $urandom & 32'h000000FF;
         reg_wr(OFF_SLOT_EN, v);
         reg_chk(OFF_SLOT_EN, v);
         v = $urandom & 32'h00000009;
         reg_wr(OFF_PAUSE_CFG, v);
         reg_chk(OFF_PAUSE_CFG, v);
      end
      $display("test registers done");
      // Start, locked configuration, feeding, then expiry with interrupt.
      do_reset();
      slotEn = 8'($urandom) | 8'h80;
      reg_wr(OFF_RELOAD_CNT, MIN_RELOAD_CNT);
      reg_wr(OFF_SLOT_EN, 32'(slotEn));
      reg_wr(OFF_INTEN_SET, 32'h00000001);
      reg_wr(OFF_START, 32'h00000001);
      reg_chk(OFF_RUN_STATE, 32'h00000001);
      reg_chk(OFF_REQ_STATE, 32'(slotEn));
      reg_wr(OFF_RELOAD_CNT, 32'h00000000);
      reg_chk(OFF_RELOAD_CNT, MIN_RELOAD_CNT);
      reg_wr(OFF_SLOT_EN, 32'h00000000);
      reg_chk(OFF_SLOT_EN, 32'(slotEn));
      reg_wr(OFF_PAUSE_CFG, 32'h00000008);
      reg_chk(OFF_PAUSE_CFG, 32'h00000001);
      repeat (6) begin
         repeat (5 * TICK) @(posedge ref_clk);
         feed_all();
      end
      reg_chk(OFF_EXPIRY, 32'h00000000);
      wait_hi(1'b0, 17 * TICK);
      check_range(n, 15 * TICK - 16, 16 * TICK + 8);
      check32(32'(wdtResetReq), 32'h00000000);
      wait_hi(1'b1, 3 * TICK);
      check_range(n, TICK, 2 * TICK + 4);
      reg_chk(OFF_EXPIRY, 32'h00000001);
      reg_wr(OFF_EXPIRY, 32'h00000000);
      reg_chk(OFF_EXPIRY, 32'h00000000);
      check32(32'(irq), 32'h00000000);
      check32(32'(wdtResetReq), 32'h00000001);
      $display("test feed and expiry done");
      // Pausing in sleep and in halt, then expiry without interrupt.
      do_reset();
      reg_wr(OFF_RELOAD_CNT, MIN_RELOAD_CNT);
      reg_wr(OFF_PAUSE_CFG, 32'h00000000);
      reg_wr(OFF_START, 32'h00000001);
      cpuSleep <= 1'b1;
      repeat (18 * TICK) @(posedge ref_clk);
      reg_chk(OFF_EXPIRY, 32'h00000000);
      cpuSleep <= 1'b0;
      cpuHalt <= 1'b1;
      repeat (18 * TICK) @(posedge ref_clk);
      reg_chk(OFF_EXPIRY, 32'h00000000);
      cpuHalt <= 1'b0;
      wait_hi(1'b1, 17 * TICK);
      check_range(n, 14 * TICK, 16 * TICK + 8);
      check32(32'(irq), 32'h00000000);
      reg_chk(OFF_EXPIRY, 32'h00000001);
      $display("test pause done");
      // Running on through sleep and halt when both fields say run.
      do_reset();
      reg_wr(OFF_RELOAD_CNT, MIN_RELOAD_CNT);
      reg_wr(OFF_PAUSE_CFG, 32'h00000009);
      cpuSleep <= 1'b1;
      cpuHalt <= 1'b1;
      reg_wr(OFF_START, 32'h00000001);
      wait_hi(1'b1, 17 * TICK);
      check_range(n, 15 * TICK, 16 * TICK + 8);
      $display("test run through done");
      summarize();
   end
endmodule
`default_nettype wire
